// ### design/lbh_pkg.sv
// Purpose: shared constants and types for the local bus lane/hold/irq block
// Assumes: single clock SYS_CLK, synchronous active-low reset
// Notes:   bus width codes select the byte strobe encoding
`default_nettype none
package lbh_pkg;

    typedef enum logic [1:0] {
        LBH_W32 = 2'b00,
        LBH_W16 = 2'b01,
        LBH_W8  = 2'b10
    } lbh_width_t;

    localparam int         LBH_LANES     = 4;
    localparam int         LBH_DATA_W    = 32;
    localparam logic [3:0] LBH_STRB_IDLE = 4'hf;
    localparam logic       LBH_REQ_RST   = 1'b0;
    localparam logic       LBH_IRQ_RST   = 1'b0;

    typedef enum logic [1:0] {
        LBH_IDLE = 2'b00,
        LBH_REQ  = 2'b01,
        LBH_XFER = 2'b10
    } lbh_state_t;

endpackage : lbh_pkg
`default_nettype wire

// ### design/lbh_if.sv
// Purpose: link between the bridge end and the processor/arbiter end
// Assumes: both ends clocked by SYS_CLK
// Notes:   request is three-stated; the arbiter end resolves the wire from req_oe
`default_nettype none
interface lbh_if;
    logic       req_out;
    logic       req_oe;
    logic       grant;
    logic [3:0] strb_n_out;
    logic       strb_oe;
    logic [3:0] strb_n_in;
    logic       irq_in_n;
    logic       irq_out_n_out;
    logic       irq_out_oe;

    modport bridge (
        output req_out, req_oe, strb_n_out, strb_oe, irq_out_n_out, irq_out_oe,
        input  grant, strb_n_in, irq_in_n
    );
    modport partner (
        input  req_out, req_oe, strb_n_out, strb_oe, irq_out_n_out, irq_out_oe,
        output grant, strb_n_in, irq_in_n
    );
endinterface : lbh_if
`default_nettype wire

// ### design/lbh_arbiter.sv
// Purpose: partner end: external arbiter, local interrupt source, strobe decode
// Assumes: request sampled on SYS_CLK; a floating request reads as low
// Notes:   grants only while the request is seen driven high
`default_nettype none
module lbh_arbiter
    import lbh_pkg::*;
(
    input  wire logic       SYS_CLK,
    input  wire logic       RESET_N,
    lbh_if.partner          link,
    input  wire logic       BUS_BUSY,
    input  wire logic       IRQ_RAISE,
    input  wire lbh_width_t WIDTH,
    output logic            GRANTED,
    output logic [3:0]      BYTE_VALID,
    output logic [1:0]      ADDR_LOW,
    output logic            IRQ_SEEN
);
    logic       grant_ff;
    logic       nxt_grant;
    logic [3:0] valid_ff;
    logic [3:0] nxt_valid;
    logic [1:0] addr_ff;
    logic [1:0] nxt_addr;
    logic       irq_ff;
    logic       nxt_irq;
    logic       req_seen;
    logic [3:0] s;

    assign req_seen = link.req_oe & link.req_out;
    assign s        = link.strb_n_out;

    always_comb begin
        // a held grant survives a busy bus; busy only blocks new grants
        nxt_grant = req_seen & (grant_ff | ~BUS_BUSY);
        nxt_irq   = ~link.irq_out_n_out & link.irq_out_oe;
        nxt_valid = 4'h0;
        nxt_addr  = 2'h0;
        if (link.strb_oe) begin
            unique case (WIDTH)
                LBH_W16: begin
                    nxt_valid = {2'b00, ~s[3], ~s[0]};
                    nxt_addr  = {s[1], 1'b0};
                end
                LBH_W8: begin
                    nxt_valid = 4'h1;
                    nxt_addr  = s[1:0];
                end
                default: nxt_valid = ~s;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            grant_ff <= 1'b0;
            valid_ff <= 4'h0;
            addr_ff  <= 2'h0;
            irq_ff   <= 1'b0;
        end else begin
            grant_ff <= nxt_grant;
            valid_ff <= nxt_valid;
            addr_ff  <= nxt_addr;
            irq_ff   <= nxt_irq;
        end
    end

    assign link.grant     = grant_ff;
    assign link.irq_in_n  = ~IRQ_RAISE;
    assign link.strb_n_in = LBH_STRB_IDLE;
    assign GRANTED        = grant_ff;
    assign BYTE_VALID     = valid_ff;
    assign ADDR_LOW       = addr_ff;
    assign IRQ_SEEN       = irq_ff;
endmodule : lbh_arbiter
`default_nettype wire

// ### design/lbh_bridge.sv
// Purpose: bridge end: bus request/grant, byte strobe encoding, interrupts
// Assumes: all pins synchronous to SYS_CLK (local clock)
// Notes:   request pin is a level plus an enable; the arbiter end resolves the float
//          strobes stand from the request until the transfer ends
//          a grant lost mid-transfer sends the engine back to requesting
//          no software-visible registers; interrupt sources arrive as plain ports
// Functional notes
// - 32-bit: strobe n qualifies byte lane n
// - 16-bit: strobe3 upper, strobe1 A1, strobe0 lower
// - 8-bit: strobes 1,0 carry address bits 1,0
// - assert request whenever bus ownership needed
// - arbiter asserts grant answering the request
// - arbiter grants only while request asserted
// - request floats in reset or unselected
// - local interrupt input raises PCI interrupt
// - interrupt output held while enabled condition persists
`default_nettype none
module lbh_bridge
    import lbh_pkg::*;
#(
    parameter int N_IRQ = 2
) (
    input  wire logic             SYS_CLK,
    input  wire logic             RESET_N,
    lbh_if.bridge                 link,
    input  wire logic             HOST_MODE_SELECT_N,
    input  wire logic             PCI_RESET_N,
    input  wire logic             LOCAL_SIDE_RESET_N,
    input  wire logic             BOARD_SELECT_N,
    input  wire lbh_width_t       WIDTH,
    input  wire logic             XFER_START,
    input  wire logic [1:0]       XFER_ADDR,
    input  wire logic [3:0]       XFER_BYTES,
    input  wire logic             XFER_LAST,
    input  wire logic [N_IRQ-1:0] IRQ_ENABLE,
    input  wire logic [N_IRQ-1:0] IRQ_COND,
    output logic                  XFER_BUSY,
    output logic                  XFER_DRIVING,
    output logic                  PCI_INTA_N
);
    // refuse builds that the encoder and the interrupt path cannot serve
    if (N_IRQ < 1) begin : g_bad_irq
        $error("N_IRQ must be at least 1");
    end
    if ((LBH_LANES != 4) || (LBH_DATA_W != 32)) begin : g_bad_bus
        $error("strobe encoder serves only four byte lanes of a 32-bit bus");
    end

    lbh_state_t       state_ff;
    lbh_state_t       nxt_state;
    logic             req_ff;
    logic             nxt_req;
    logic [3:0]       strb_ff;
    logic [3:0]       nxt_strb;
    logic             drive_ff;
    logic             nxt_drive;
    logic             inta_ff;
    logic             nxt_inta;
    logic             lirq_ff;
    logic             nxt_lirq;
    logic             float_req;
    logic             take_start;
    logic             grant_gone;
    logic             xfer_done;
    logic [3:0]       enc;
    logic [N_IRQ-1:0] active;

    // pin float conditions are combinational so the pin releases at once
    assign float_req = (HOST_MODE_SELECT_N & ~PCI_RESET_N)
                     | (~HOST_MODE_SELECT_N & ~LOCAL_SIDE_RESET_N)
                     | BOARD_SELECT_N;

    // transfer events for the state group; the strobe group also uses take_start and xfer_done
    assign take_start = (state_ff == LBH_IDLE) & XFER_START;
    assign grant_gone = (state_ff == LBH_XFER) & ~link.grant;
    assign xfer_done  = (state_ff == LBH_XFER) & link.grant & XFER_LAST;

    genvar i;
    generate
        for (i = 0; i < N_IRQ; i++) begin : g_irq
            assign active[i] = IRQ_ENABLE[i] & IRQ_COND[i];
        end
    endgenerate

    always_comb begin
        enc = ~XFER_BYTES;
        unique case (WIDTH)
            LBH_W16: enc = {~XFER_BYTES[1], 1'b1, XFER_ADDR[1], ~XFER_BYTES[0]};
            LBH_W8:  enc = {2'b11, XFER_ADDR};
            default: enc = ~XFER_BYTES;
        endcase
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            LBH_IDLE: begin
                if (take_start) begin
                    nxt_state = LBH_REQ;
                end
            end
            LBH_REQ: begin
                if (link.grant) begin
                    nxt_state = LBH_XFER;
                end
            end
            LBH_XFER: begin
                // losing grant mid-transfer backs off and re-requests
                if (grant_gone) begin
                    nxt_state = LBH_REQ;
                end else if (xfer_done) begin
                    nxt_state = LBH_IDLE;
                end
            end
            default: nxt_state = LBH_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            state_ff <= LBH_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // the request pin comes straight from a flop so it never glitches between edges
    always_comb begin
        nxt_req = (nxt_state != LBH_IDLE);
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            req_ff <= LBH_REQ_RST;
        end else begin
            req_ff <= nxt_req;
        end
    end

    // strobes are captured with the request and held until the transfer ends,
    // so the far end sees one stable lane pattern for the whole ownership
    always_comb begin
        nxt_strb = strb_ff;
        if (take_start) begin
            nxt_strb = enc;
        end else if (xfer_done) begin
            nxt_strb = LBH_STRB_IDLE;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            strb_ff <= LBH_STRB_IDLE;
        end else begin
            strb_ff <= nxt_strb;
        end
    end

    // drive only after a sampled grant; the pin enable also gates on the live
    // grant so a withdrawn grant releases the strobes at once
    always_comb begin
        nxt_drive = 1'b0;
        if (link.grant) begin
            if (state_ff == LBH_REQ) begin
                nxt_drive = 1'b1;
            end else if ((state_ff == LBH_XFER) && !XFER_LAST) begin
                nxt_drive = 1'b1;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            drive_ff <= 1'b0;
        end else begin
            drive_ff <= nxt_drive;
        end
    end

    // registered, so the output drops one cycle after the last cause clears
    always_comb begin
        nxt_inta = ~link.irq_in_n;
        nxt_lirq = |active;
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            inta_ff <= LBH_IRQ_RST;
            lirq_ff <= LBH_IRQ_RST;
        end else begin
            inta_ff <= nxt_inta;
            lirq_ff <= nxt_lirq;
        end
    end

    assign link.req_out       = req_ff;
    assign link.req_oe        = ~float_req;
    assign link.strb_n_out    = strb_ff;
    assign link.strb_oe       = drive_ff & link.grant;
    assign link.irq_out_n_out = 1'b0;
    assign link.irq_out_oe    = lirq_ff;
    assign XFER_BUSY          = req_ff;
    assign XFER_DRIVING       = drive_ff;
    assign PCI_INTA_N         = ~inta_ff;
endmodule : lbh_bridge
`default_nettype wire

// ### verif/lbh_properties.sv
// Purpose: concurrent checks on the link between bridge and arbiter ends
// Assumes: one clock, synchronous active-low reset
// Notes:   watches only the link, so width-dependent strobe values are left to the bench
`default_nettype none
module lbh_properties
    import lbh_pkg::*;
(
    input wire logic       SYS_CLK,
    input wire logic       RESET_N,
    input wire logic       req_out,
    input wire logic       req_oe,
    input wire logic       grant,
    input wire logic [3:0] strb_n_out,
    input wire logic       strb_oe,
    input wire logic       irq_out_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_handover;
        req_out && grant ##1 req_out && grant;
    endsequence
    sequence s_release;
        $fell(req_out);
    endsequence
    chk_grant_after_req: assert property ($rose(grant) |-> $past(req_oe && req_out))
        else $error("grant rose without a driven request");
    chk_grant_drops: assert property (!(req_oe && req_out) |=> !grant)
        else $error("grant kept without a driven request");
    chk_idle_strobes: assert property (!req_out |-> strb_n_out == LBH_STRB_IDLE)
        else $error("strobes active while not requesting");
    chk_strb_held: assert property (req_out ##1 req_out |-> $stable(strb_n_out))
        else $error("strobes changed within a request");
    chk_drive_granted: assert property (strb_oe |-> $past(grant) && req_out)
        else $error("strobes driven without grant");
    chk_grant_to_drive: assert property (s_handover |-> strb_oe)
        else $error("grant did not start driving");
    chk_req_until_done: assert property (s_release |-> $past(strb_oe) && !strb_oe)
        else $error("request dropped before the transfer");
    chk_irq_open_drain: assert property (irq_out_n_out == 1'b0)
        else $error("interrupt output drives high");
endmodule : lbh_properties
`default_nettype wire

// ### verif/lbh_tb.sv
// Purpose: self-checking bench joining the bridge and arbiter ends
// Assumes: inputs change 2 ns after the rising edge
// Notes:   strobe encodings per width come from the row table
`default_nettype none
module lbh_tb
    import lbh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {lbh_width_t w; logic [1:0] a; logic [3:0] b; logic [3:0] e;
                           logic [3:0] v; logic [1:0] l;} lbh_row_t;
    localparam lbh_row_t ROWS [6] = '{'{LBH_W32, 2'h0, 4'h5, 4'ha, 4'h5, 2'h0},
        '{LBH_W32, 2'h3, 4'hf, 4'h0, 4'hf, 2'h0}, '{LBH_W16, 2'h2, 4'h1, 4'he, 4'h1, 2'h2},
        '{LBH_W16, 2'h0, 4'h2, 4'h5, 4'h2, 2'h0}, '{LBH_W8, 2'h3, 4'h1, 4'hf, 4'h1, 2'h3},
        '{LBH_W8, 2'h1, 4'h1, 4'hd, 4'h1, 2'h1}};
    localparam logic [4:0] SEL [5] = '{5'h14, 5'h08, 5'h1e, 5'h19, 5'h05};
    localparam logic [4:0] IRQ [4] = '{5'h12, 5'h0b, 5'h08, 5'h1d};
    logic       SYS_CLK = 1'b0, RESET_N = 1'b0, start = 1'b0, last = 1'b0, busy = 1'b0;
    logic       host_n = 1'b1, pci_n = 1'b1, lrst_n = 1'b1, bsel_n = 1'b0, raise = 1'b0;
    logic [1:0] addr = 2'h0, en = 2'h0, cond = 2'h0;
    logic [3:0] bytes = 4'h0;
    logic       xbusy, drv, inta_n, granted, irq_seen;
    logic       prev = 1'b0;
    logic [3:0] valid;
    logic [1:0] addr_low;
    lbh_width_t width = LBH_W32;
    int         failures = 0, comparisons = 0, k;
    lbh_if link ();
    lbh_bridge u_lbh_bridge (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .link(link),
        .HOST_MODE_SELECT_N(host_n), .PCI_RESET_N(pci_n), .LOCAL_SIDE_RESET_N(lrst_n),
        .BOARD_SELECT_N(bsel_n), .WIDTH(width), .XFER_START(start), .XFER_ADDR(addr),
        .XFER_BYTES(bytes), .XFER_LAST(last), .IRQ_ENABLE(en), .IRQ_COND(cond),
        .XFER_BUSY(xbusy), .XFER_DRIVING(drv), .PCI_INTA_N(inta_n));
    lbh_arbiter u_lbh_arbiter (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .link(link),
        .BUS_BUSY(busy), .IRQ_RAISE(raise), .WIDTH(width), .GRANTED(granted),
        .BYTE_VALID(valid), .ADDR_LOW(addr_low), .IRQ_SEEN(irq_seen));
    lbh_properties u_lbh_properties (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
        .req_out(link.req_out), .req_oe(link.req_oe), .grant(link.grant),
        .strb_n_out(link.strb_n_out), .strb_oe(link.strb_oe),
        .irq_out_n_out(link.irq_out_n_out));
    task automatic step();
        @(posedge SYS_CLK);
        #2;
    endtask : step
    task automatic check(logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic do_reset();
        RESET_N = 1'b0;
        repeat (2) step();
        check({link.req_out, link.strb_oe, link.irq_out_oe, inta_n, link.strb_n_out}, 8'h1f);
        RESET_N = 1'b1;
    endtask : do_reset
    // waits for the strobes to be driven, then ends the transfer and checks the release
    task automatic finish(logic [3:0] exp, logic [5:0] dec);
        for (k = 0; k < 20 && link.strb_oe !== 1'b1; k++) step();
        check(link.strb_n_out, exp);
        check({drv, granted}, 8'h3);
        last = 1'b1;
        step();
        last = 1'b0;
        check({xbusy, link.req_out, link.strb_oe, link.strb_n_out}, 8'h0f);
        check({addr_low, valid}, dec);
        step();
    endtask : finish
    initial begin
        forever #10 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        #20000;
        failures++;
        complete_run();
    end
    initial begin
        do_reset();
        $display("reset test done");
        foreach (ROWS[i]) begin
            {width, addr, bytes} = {ROWS[i].w, ROWS[i].a, ROWS[i].b};
            start = 1'b1;
            step();
            start = 1'b0;
            finish(ROWS[i].e, {ROWS[i].l, ROWS[i].v});
        end
        $display("strobe table done");
        foreach (SEL[i]) begin
            {host_n, pci_n, lrst_n, bsel_n} = SEL[i][4:1];
            step();
            check(link.req_oe, SEL[i][0]);
        end
        {host_n, pci_n, lrst_n, bsel_n} = 4'he;
        $display("float test done");
        // a busy bus must leave the request pending, then unselecting mid-transfer floats it and withdraws the grant
        busy = 1'b1;
        start = 1'b1;
        step();
        start = 1'b0;
        repeat (4) step();
        check({link.req_out, link.grant}, 8'h2);
        busy = 1'b0;
        for (k = 0; k < 20 && link.strb_oe !== 1'b1; k++) step();
        bsel_n = 1'b1;
        repeat (3) step();
        check({link.grant, link.strb_oe, link.req_out, drv}, 8'h2);
        bsel_n = 1'b0;
        finish(4'hd, 6'h11);
        $display("grant test done");
        raise = 1'b1;
        step();
        check(inta_n, 1'b0);
        raise = 1'b0;
        step();
        check(inta_n, 1'b1);
        foreach (IRQ[i]) begin
            {en, cond} = IRQ[i][4:1];
            step();
            check({irq_seen, link.irq_out_oe}, {prev, IRQ[i][0]});
            prev = IRQ[i][0];
        end
        $display("interrupt test done");
        start = 1'b1;
        step();
        start = 1'b0;
        repeat (3) step();
        do_reset();
        step();
        check({link.req_out, link.irq_out_oe}, 8'h1);
        $display("mid-run reset test done");
        complete_run();
    end
endmodule : lbh_tb
`default_nettype wire
